// [src/mis_pkg.sv]
package mis_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LPI_CSR_OFFSET = 8'h30;
  localparam logic [7:0] STATUS_OFFSET = 8'h38;
  localparam logic [7:0] MASK_OFFSET = 8'h3c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LPI_BIT = 10;
  localparam int TS_BIT = 9;
  localparam int CSUM_BIT = 7;
  localparam int TXCNT_BIT = 6;
  localparam int RXCNT_BIT = 5;
  localparam int SUMMARY_BIT = 4;
  localparam int WAKE_BIT = 3;
  localparam int RGL_BIT = 0;
  localparam int TX_ENTRY_BIT = 0;
  localparam int TX_EXIT_BIT = 1;
  localparam int RX_ENTRY_BIT = 2;
  localparam int RX_EXIT_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [3:0] LPI_CSR_RESET = 4'h0;
  localparam logic FLAG_RESET = 1'b0;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mis_apb_req_t;

  // Idle entry and exit pulses from the idle controller.
  typedef struct packed {
    logic rxExit;
    logic rxEntry;
    logic txExit;
    logic txEntry;
  } mis_lpi_evt_t;

  // Counter interrupt registers, reduced to "any bit set".
  typedef struct packed {
    logic checksumAny;
    logic txAny;
    logic rxAny;
  } mis_cnt_irq_t;

endpackage : mis_pkg

// [src/mis_sticky_bit.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Sticky flag: a set pulse holds it high until a clear; set wins.
// ------------------------------------------------------------------
module mis_sticky_bit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic set,
  input wire logic clear,
  output logic flag
);
  import mis_pkg::*;

  // A set in the cycle of a clear must not be lost, so set has priority.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag <= FLAG_RESET;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule : mis_sticky_bit

// [src/mis_irq_status.sv]
`timescale 1ns/1ps
module mis_irq_status #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input mis_pkg::mis_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input mis_pkg::mis_lpi_evt_t lpiEvt,
  input wire logic tsTargetReached,
  input wire logic tsSecondsOverflow,
  input wire logic tsStatusRead,
  input mis_pkg::mis_cnt_irq_t cntIrq,
  input wire logic magicPacketSeen,
  input wire logic wakeFrameSeen,
  input wire logic powerDownMode,
  input wire logic [1:0] wakeReasonBits,
  output logic macIrqOut
);
  import mis_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (ADDR_W != 8) begin : g_badWidth
      $error("mis_irq_status serves an 8-bit register address only.");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setupRead;
  logic accessWrite;
  logic hitLpiCsr;
  logic hitStatus;
  logic hitMask;
  logic hitAny;

  // Read side effects act at the setup edge, when the read value is latched,
  // so an event in the same cycle is kept by the flag and shows next read.
  assign hitLpiCsr = (apbReq.paddr == LPI_CSR_OFFSET);
  assign hitStatus = (apbReq.paddr == STATUS_OFFSET);
  assign hitMask = (apbReq.paddr == MASK_OFFSET);
  assign hitAny = hitLpiCsr | hitStatus | hitMask;
  assign setupRead = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign accessWrite = apbReq.psel & apbReq.penable & apbReq.pwrite & pready;

  // ----------------------------------------------------------------
  // Idle controller status bits
  // ----------------------------------------------------------------
  logic [3:0] lpiCsrBits;
  logic lpiCsrRead;
  logic [3:0] lpiEvtBits;

  assign lpiCsrRead = setupRead & hitLpiCsr;
  assign lpiEvtBits = lpiEvt;

  // Each entry or exit event has its own read-to-clear bit.
  for (genvar i = 0; i < 4; i++) begin : g_lpiBits
    mis_sticky_bit u_lpiBit (
      .clk(clk),
      .resetn(resetn),
      .set(lpiEvtBits[i]),
      .clear(lpiCsrRead),
      .flag(lpiCsrBits[i])
    );
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic lpiFlag;
  logic tsFlag;
  logic wakeFlag;
  logic lpiAnyEvt;
  logic tsEvt;
  logic wakeEvt;
  logic wakeReasonsClear;

  assign lpiAnyEvt = |lpiEvtBits;
  assign tsEvt = tsTargetReached | tsSecondsOverflow;
  assign wakeEvt = (magicPacketSeen | wakeFrameSeen) & powerDownMode;
  assign wakeReasonsClear = (wakeReasonBits == 2'b00);

  // Idle flag: any entry or exit; cleared by reading the idle register.
  mis_sticky_bit u_lpiFlag (
    .clk(clk),
    .resetn(resetn),
    .set(lpiAnyEvt),
    .clear(lpiCsrRead),
    .flag(lpiFlag)
  );

  // Timestamp flag: target reached or seconds overflow.
  mis_sticky_bit u_tsFlag (
    .clk(clk),
    .resetn(resetn),
    .set(tsEvt),
    .clear(tsStatusRead),
    .flag(tsFlag)
  );

  // Wake flag: held until both reason bits have been read away.
  mis_sticky_bit u_wakeFlag (
    .clk(clk),
    .resetn(resetn),
    .set(wakeEvt),
    .clear(wakeReasonsClear),
    .flag(wakeFlag)
  );

  // ----------------------------------------------------------------
  // Counter flags
  // ----------------------------------------------------------------
  logic csumFlag;
  logic txCntFlag;
  logic rxCntFlag;
  logic summaryFlag;

  // Counter flags track their source registers; they clear only when empty.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csumFlag <= FLAG_RESET;
      txCntFlag <= FLAG_RESET;
      rxCntFlag <= FLAG_RESET;
    end else begin
      csumFlag <= cntIrq.checksumAny;
      txCntFlag <= cntIrq.txAny;
      rxCntFlag <= cntIrq.rxAny;
    end
  end

  assign summaryFlag = csumFlag | txCntFlag | rxCntFlag;

  // ----------------------------------------------------------------
  // Status and mask words
  // ----------------------------------------------------------------
  logic [31:0] statusWord;
  logic [31:0] maskWord;
  logic [31:0] maskWritable;
  logic [31:0] pending;

  // Reserved bits stay zero; the link flag is held inactive.
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[LPI_BIT] = lpiFlag;
    statusWord[TS_BIT] = tsFlag;
    statusWord[CSUM_BIT] = csumFlag;
    statusWord[TXCNT_BIT] = txCntFlag;
    statusWord[RXCNT_BIT] = rxCntFlag;
    statusWord[SUMMARY_BIT] = summaryFlag;
    statusWord[WAKE_BIT] = wakeFlag;
    statusWord[RGL_BIT] = 1'b0;
  end

  // Only the four documented mask bits hold a value.
  always_comb begin
    maskWritable = 32'h0000_0000;
    maskWritable[LPI_BIT] = 1'b1;
    maskWritable[TS_BIT] = 1'b1;
    maskWritable[WAKE_BIT] = 1'b1;
    maskWritable[RGL_BIT] = 1'b1;
  end

  // Mask register; status register writes are dropped.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      maskWord <= MASK_RESET;
    end else if (accessWrite && hitMask) begin
      maskWord <= apbReq.pwdata & maskWritable;
    end
  end

  // Masked flags drop out; counter and summary bits have no mask.
  assign pending = statusWord & ~maskWord;

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      macIrqOut <= 1'b0;
    end else begin
      macIrqOut <= |pending;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] readMux;

  // Read value selection; unmapped addresses read zero.
  always_comb begin
    readMux = 32'h0000_0000;
    if (hitLpiCsr) begin
      readMux = {28'h0000000, lpiCsrBits};
    end else if (hitStatus) begin
      readMux = statusWord;
    end else if (hitMask) begin
      readMux = maskWord;
    end
  end

  // Zero-wait slave: ready in the first access cycle, error on unmapped.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbReq.psel & ~apbReq.penable;
      pslverr <= apbReq.psel & ~apbReq.penable & ~hitAny;
    end
  end

  // Read data is latched at the setup edge and held through the access.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (setupRead) begin
      prdata <= readMux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_lpiCsrRead;
    apbReq.psel && !apbReq.penable && !apbReq.pwrite && apbReq.paddr == LPI_CSR_OFFSET;
  endsequence

  sequence s_maskWrite;
    apbReq.psel && !apbReq.penable && apbReq.pwrite && apbReq.paddr == MASK_OFFSET
      ##1 apbReq.psel && apbReq.penable && pready;
  endsequence

  property p_lpiSet;
    @(posedge clk) disable iff (!resetn)
      (|lpiEvtBits) |=> lpiFlag ##1 (lpiFlag || $past(lpiCsrRead));
  endproperty
  a_lpiSet: assert property (p_lpiSet) else $error("Idle flag not set by event.");

  property p_lpiClr;
    @(posedge clk) disable iff (!resetn)
      (s_lpiCsrRead and !(|lpiEvtBits)) |=> !lpiFlag && lpiCsrBits == 4'h0;
  endproperty
  a_lpiClr: assert property (p_lpiClr) else $error("Idle flags not cleared by read.");

  property p_tsTarget;
    @(posedge clk) disable iff (!resetn)
      tsTargetReached |=> tsFlag;
  endproperty
  a_tsTarget: assert property (p_tsTarget) else $error("Target time did not flag.");

  property p_tsOverflow;
    @(posedge clk) disable iff (!resetn)
      tsSecondsOverflow |=> tsFlag;
  endproperty
  a_tsOverflow: assert property (p_tsOverflow) else $error("Overflow did not flag.");

  property p_tsClr;
    @(posedge clk) disable iff (!resetn)
      tsStatusRead && !tsEvt |=> !tsFlag;
  endproperty
  a_tsClr: assert property (p_tsClr) else $error("Timestamp flag not cleared.");

  property p_cntTrack;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> csumFlag == $past(cntIrq.checksumAny) && txCntFlag == $past(cntIrq.txAny)
        && rxCntFlag == $past(cntIrq.rxAny);
  endproperty
  a_cntTrack: assert property (p_cntTrack) else $error("Counter flag wrong.");

  property p_summary;
    @(posedge clk) disable iff (!resetn)
      $rose(cntIrq.txAny) |=> statusWord[SUMMARY_BIT] ##1 (statusWord[SUMMARY_BIT]
        || !$past(cntIrq.txAny));
  endproperty
  a_summary: assert property (p_summary) else $error("Summary flag wrong.");

  property p_wake;
    @(posedge clk) disable iff (!resetn)
      (wakeEvt |=> wakeFlag) and (!wakeEvt && wakeReasonsClear |=> !wakeFlag);
  endproperty
  a_wake: assert property (p_wake) else $error("Wake flag wrong.");

  property p_linkQuiet;
    @(posedge clk) disable iff (!resetn)
      setupRead && hitStatus |=> prdata[RGL_BIT] == 1'b0 && prdata[31:11] == 21'h000000;
  endproperty
  a_linkQuiet: assert property (p_linkQuiet) else $error("Reserved bit set.");

  property p_maskGate;
    @(posedge clk) disable iff (!resetn)
      maskWord[LPI_BIT] && maskWord[TS_BIT] && maskWord[WAKE_BIT] && !summaryFlag
        |=> !macIrqOut;
  endproperty
  a_maskGate: assert property (p_maskGate) else $error("Masked irq.");

  property p_irqLevel;
    @(posedge clk) disable iff (!resetn)
      (summaryFlag || (lpiFlag && !maskWord[LPI_BIT])) |=> macIrqOut;
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("Pending flag gave no irq.");

  property p_maskWrite;
    @(posedge clk) disable iff (!resetn)
      s_maskWrite |=> maskWord == ($past(apbReq.pwdata) & maskWritable);
  endproperty
  a_maskWrite: assert property (p_maskWrite) else $error("Mask write wrong.");

  property p_lpiBits;
    @(posedge clk) disable iff (!resetn)
      lpiEvt.rxExit |=> lpiCsrBits[RX_EXIT_BIT];
  endproperty
  a_lpiBits: assert property (p_lpiBits) else $error("Idle exit bit not set.");

  property p_lpiEntry;
    @(posedge clk) disable iff (!resetn)
      lpiEvt.txEntry |=> lpiCsrBits[TX_ENTRY_BIT];
  endproperty
  a_lpiEntry: assert property (p_lpiEntry) else $error("Idle entry bit not set.");

  property p_wakeGate;
    @(posedge clk) disable iff (!resetn)
      !powerDownMode && !wakeFlag |=> !wakeFlag;
  endproperty
  a_wakeGate: assert property (p_wakeGate) else $error("Wake flag set wrongly.");

  property p_irqPass;
    @(posedge clk) disable iff (!resetn)
      ((tsFlag && !maskWord[TS_BIT]) |=> macIrqOut)
        and ((wakeFlag && !maskWord[WAKE_BIT]) |=> macIrqOut);
  endproperty
  a_irqPass: assert property (p_irqPass) else $error("Unmasked flag gave no irq.");

  property p_irqQuiet;
    @(posedge clk) disable iff (!resetn)
      !lpiFlag && !tsFlag && !wakeFlag && !summaryFlag |=> !macIrqOut;
  endproperty
  a_irqQuiet: assert property (p_irqQuiet) else $error("Irq with no flag set.");

  property p_badAddr;
    @(posedge clk) disable iff (!resetn)
      apbReq.psel && !apbReq.penable && !hitAny |=> pready && pslverr;
  endproperty
  a_badAddr: assert property (p_badAddr) else $error("Unmapped access gave no error.");

endmodule : mis_irq_status

// [sim/mis_irq_status_tb.sv]
`timescale 1ns/1ps
module mis_irq_status_tb;
  import mis_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk;
  logic resetn;
  mis_apb_req_t apbReq;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mis_lpi_evt_t lpiEvt;
  logic tsTargetReached;
  logic tsSecondsOverflow;
  logic tsStatusRead;
  mis_cnt_irq_t cntIrq;
  logic magicPacketSeen;
  logic wakeFrameSeen;
  logic powerDownMode;
  logic [1:0] wakeReasonBits;
  logic macIrqOut;
  int numErrors;
  int checkCount;
  logic [31:0] rdData;
  logic rdErr;

  // The block under test.
  mis_irq_status #(.ADDR_W(8)) u_mis_irq_status (
    .clk(clk),
    .resetn(resetn),
    .apbReq(apbReq),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .lpiEvt(lpiEvt),
    .tsTargetReached(tsTargetReached),
    .tsSecondsOverflow(tsSecondsOverflow),
    .tsStatusRead(tsStatusRead),
    .cntIrq(cntIrq),
    .magicPacketSeen(magicPacketSeen),
    .wakeFrameSeen(wakeFrameSeen),
    .powerDownMode(powerDownMode),
    .wakeReasonBits(wakeReasonBits),
    .macIrqOut(macIrqOut)
  );

  // The clock runs at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task report_and_stop;
    if (numErrors == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Compares one word and counts the result.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      numErrors++;
      report_and_stop();
    end else begin
      rdData = prdata;
      rdErr = pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
    end
  endtask : apb

  // Reads a register and compares the word.
  task rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    chk(rdData, exp);
  endtask : rd_chk

  // Lets cycles pass, then steps clear of the edge so outputs are settled.
  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // Compares the interrupt line, stepped clear of the clock edge.
  task irq_chk(input logic exp);
    #1;
    chk({31'h0, macIrqOut}, {31'h0, exp});
  endtask : irq_chk

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Reset values, writable mask bits, read-only status and an unmapped address.
  task t_regs;
    rd_chk(MASK_OFFSET, 32'h0000_0000);
    rd_chk(STATUS_OFFSET, 32'h0000_0000);
    irq_chk(1'b0);
    apb(1'b1, MASK_OFFSET, 32'hffff_ffff);
    rd_chk(MASK_OFFSET, 32'h0000_0609);
    settle(2);
    irq_chk(1'b0);
    apb(1'b1, STATUS_OFFSET, 32'hffff_ffff);
    rd_chk(STATUS_OFFSET, 32'h0000_0000);
    rd_chk(8'h44, 32'h0000_0000);
    chk({31'h0, rdErr}, 32'h0000_0001);
    apb(1'b1, MASK_OFFSET, 32'h0000_0000);
  endtask : t_regs

  // Each idle entry or exit sets the idle flag; reading the idle register clears it.
  task t_lpi;
    for (int i = 0; i < 5; i++) begin
      if (i == 4) apb(1'b1, MASK_OFFSET, 32'h0000_0400);
      @(posedge clk);
      lpiEvt <= mis_lpi_evt_t'(4'(1 << (i % 4)));
      @(posedge clk);
      lpiEvt <= '0;
      settle(2);
      irq_chk(i < 4);
      rd_chk(STATUS_OFFSET, 32'h0000_0400);
      rd_chk(LPI_CSR_OFFSET, 32'(1 << (i % 4)));
      rd_chk(LPI_CSR_OFFSET, 32'h0000_0000);
      rd_chk(STATUS_OFFSET, 32'h0000_0000);
    end
    apb(1'b1, MASK_OFFSET, 32'h0000_0000);
  endtask : t_lpi

  // Target time and seconds overflow both set the timestamp flag.
  task t_ts;
    for (int j = 0; j < 3; j++) begin
      if (j == 2) apb(1'b1, MASK_OFFSET, 32'h0000_0200);
      @(posedge clk);
      tsTargetReached <= (j == 0);
      tsSecondsOverflow <= (j != 0);
      @(posedge clk);
      tsTargetReached <= 1'b0;
      tsSecondsOverflow <= 1'b0;
      settle(2);
      irq_chk(j < 2);
      rd_chk(STATUS_OFFSET, 32'h0000_0200);
      rd_chk(STATUS_OFFSET, 32'h0000_0200);
      @(posedge clk);
      tsStatusRead <= 1'b1;
      @(posedge clk);
      tsStatusRead <= 1'b0;
      rd_chk(STATUS_OFFSET, 32'h0000_0000);
    end
    apb(1'b1, MASK_OFFSET, 32'h0000_0000);
  endtask : t_ts

  // Counter flags follow their sources and cannot be masked.
  task t_cnt;
    apb(1'b1, MASK_OFFSET, 32'h0000_0609);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      cntIrq <= mis_cnt_irq_t'(3'(1 << k));
      settle(3);
      rd_chk(STATUS_OFFSET, 32'(1 << (5 + k)) | 32'h0000_0010);
      irq_chk(1'b1);
      @(posedge clk);
      cntIrq <= '0;
      settle(3);
      rd_chk(STATUS_OFFSET, 32'h0000_0000);
      irq_chk(1'b0);
    end
    apb(1'b1, MASK_OFFSET, 32'h0000_0000);
  endtask : t_cnt

  // Wake events count only in power-down; the flag clears with the reason bits.
  task t_wake;
    wakeReasonBits <= 2'b01;
    for (int m = 0; m < 4; m++) begin
      if (m == 3) apb(1'b1, MASK_OFFSET, 32'h0000_0008);
      @(posedge clk);
      powerDownMode <= (m != 0);
      magicPacketSeen <= (m != 2);
      wakeFrameSeen <= (m == 2);
      @(posedge clk);
      magicPacketSeen <= 1'b0;
      wakeFrameSeen <= 1'b0;
      settle(2);
      irq_chk(m == 1 || m == 2);
      rd_chk(STATUS_OFFSET, (m == 0) ? 32'h0 : 32'h0000_0008);
      @(posedge clk);
      wakeReasonBits <= 2'b00;
      settle(2);
      rd_chk(STATUS_OFFSET, 32'h0000_0000);
      wakeReasonBits <= 2'b10;
    end
  endtask : t_wake

  // A reset in mid-run drops the interrupt and clears the mask and every flag.
  task t_reset;
    apb(1'b1, MASK_OFFSET, 32'h0000_0208);
    @(posedge clk);
    lpiEvt <= mis_lpi_evt_t'(4'h8);
    @(posedge clk);
    lpiEvt <= '0;
    settle(2);
    irq_chk(1'b1);
    @(posedge clk);
    resetn <= 1'b0;
    settle(1);
    irq_chk(1'b0);
    @(posedge clk);
    resetn <= 1'b1;
    rd_chk(MASK_OFFSET, 32'h0000_0000);
    rd_chk(LPI_CSR_OFFSET, 32'h0000_0000);
    rd_chk(STATUS_OFFSET, 32'h0000_0000);
  endtask : t_reset

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  // Drives every input at time zero, resets, then runs the scenarios.
  initial begin
    numErrors = 0;
    checkCount = 0;
    resetn = 1'b0;
    apbReq = '0;
    lpiEvt = '0;
    tsTargetReached = 1'b0;
    tsSecondsOverflow = 1'b0;
    tsStatusRead = 1'b0;
    cntIrq = '0;
    magicPacketSeen = 1'b0;
    wakeFrameSeen = 1'b0;
    powerDownMode = 1'b0;
    wakeReasonBits = 2'b00;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_lpi();
    t_ts();
    t_cnt();
    t_wake();
    t_reset();
    report_and_stop();
  end
endmodule : mis_irq_status_tb
